//--- core/atac_regs.svh
/*
 * Register offsets, field positions, reset values and timing for the threshold alert control block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ATAC_REGS_SVH
`define ATAC_REGS_SVH

`define ATAC_PTR_CONFIG 2'h1
`define ATAC_PTR_LOWER 2'h2
`define ATAC_PTR_UPPER 2'h3
`define ATAC_CFG_RESET 16'h8583
`define ATAC_LOWER_RESET 16'h8000
`define ATAC_UPPER_RESET 16'h7fff
`define ATAC_BIT_WINDOW 4
`define ATAC_BIT_POLARITY 3
`define ATAC_BIT_HOLD 2
`define ATAC_QUE_HI 1
`define ATAC_QUE_LO 0
`define ATAC_BIT_STATUS 15
`define ATAC_BIT_MODE 8
`define ATAC_QUE_DISABLE 2'h3
`define ATAC_QUE_ONE 2'h0
`define ATAC_QUE_TWO 2'h1
`define ATAC_QUE_FOUR 2'h2
`define ATAC_CNT_ONE 3'h1
`define ATAC_CNT_TWO 3'h2
`define ATAC_CNT_FOUR 3'h4
`define ATAC_READY_PULSE_NS 10
`define ATAC_CLK_NS 5
`define ATAC_READY_PULSE_CYC 4'((`ATAC_READY_PULSE_NS + `ATAC_CLK_NS - 1) / `ATAC_CLK_NS)

`endif

//--- core/atac_pkg.sv
/*
 * Types for the threshold alert control block.
 * Assumes the register header supplies all numeric constants.
 */
package atac_pkg;
    typedef enum logic [2:0] {
        ATAC_IDLE = 3'b001,
        ATAC_ALERT = 3'b010,
        ATAC_READY = 3'b100
    } atac_state_t;
endpackage : atac_pkg

//--- core/atac_core.sv
/*
 * Threshold comparator and alert/ready pin control of a converter.
 * Assumes a bus front end that decodes register writes and reads, pulses conversion-done and
 * alert-response strobes on CLOCK_IN, and supplies the bus address; all inputs are synchronous.
 */
`include "atac_regs.svh"
module atac_core (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire logic WR_EN_IN,
    input wire logic [1:0] WR_PTR_IN,
    input wire logic [15:0] WR_DATA_IN,
    input wire logic [1:0] RD_PTR_IN,
    output logic [15:0] RD_DATA_OUT,
    input wire logic DATA_READ_IN,
    input wire logic CONV_DONE_IN,
    input wire logic [15:0] CONV_RESULT_IN,
    input wire logic CONV_BUSY_IN,
    input wire logic ARA_IN,
    input wire logic [6:0] OWN_ADDR_IN,
    input wire logic [6:0] ARA_BUS_ADDR_IN,
    output logic ARA_ADDR_VALID_OUT,
    output logic [6:0] ARA_ADDR_OUT,
    output logic ALERT_O_OUT,
    output logic ALERT_OE_OUT
);
    logic [15:0] cfg_ff;
    logic [15:0] upper_limit_ff;
    logic [15:0] lower_limit_ff;
    logic [2:0] exceed_cnt_ff;
    logic alert_ff;
    logic [3:0] pulse_cnt_ff;
    logic [15:0] rd_data_ff;
    logic ara_valid_ff;
    logic [6:0] ara_addr_ff;
    atac_pkg::atac_state_t state_ff;
    logic [1:0] alert_queue_count;
    logic alert_pin_polarity;
    logic alert_hold_enable;
    logic window_mode;
    logic ready_mode;
    logic above;
    logic below;
    logic exceed;
    logic [2:0] need_cnt;
    logic [2:0] nxt_exceed_cnt;
    logic nxt_alert;
    logic active;
    logic conversion_status_bit;

    assign alert_queue_count = cfg_ff[`ATAC_QUE_HI:`ATAC_QUE_LO];
    assign alert_pin_polarity = cfg_ff[`ATAC_BIT_POLARITY];
    assign alert_hold_enable = cfg_ff[`ATAC_BIT_HOLD];
    assign window_mode = cfg_ff[`ATAC_BIT_WINDOW];
    assign ready_mode = upper_limit_ff[15] & ~lower_limit_ff[15];
    assign conversion_status_bit = ~CONV_BUSY_IN;
    assign above = $signed(CONV_RESULT_IN) > $signed(upper_limit_ff);
    assign below = $signed(CONV_RESULT_IN) < $signed(lower_limit_ff);

    always_comb begin
        exceed = above | (window_mode & below);
        case (alert_queue_count)
            `ATAC_QUE_ONE: need_cnt = `ATAC_CNT_ONE;
            `ATAC_QUE_TWO: need_cnt = `ATAC_CNT_TWO;
            `ATAC_QUE_FOUR: need_cnt = `ATAC_CNT_FOUR;
            default: need_cnt = `ATAC_CNT_FOUR;
        endcase
        nxt_exceed_cnt = exceed_cnt_ff;
        nxt_alert = alert_ff;
        if (CONV_DONE_IN) begin
            if (exceed) begin
                nxt_exceed_cnt = (exceed_cnt_ff < need_cnt) ? exceed_cnt_ff + 3'h1 : exceed_cnt_ff;
                if (nxt_exceed_cnt >= need_cnt) begin
                    nxt_alert = 1'b1;
                end
            end else begin
                nxt_exceed_cnt = 3'h0;
                if (!alert_hold_enable) begin
                    // Traditional releases below lower; window releases inside both
                    if (window_mode || below) begin
                        nxt_alert = 1'b0;
                    end
                end
            end
        end
        if (alert_hold_enable && (DATA_READ_IN || (ARA_IN && ARA_BUS_ADDR_IN >= OWN_ADDR_IN))) begin
            if (!(CONV_DONE_IN && exceed && nxt_exceed_cnt >= need_cnt)) begin
                nxt_alert = 1'b0;
            end
        end
        if (alert_queue_count == `ATAC_QUE_DISABLE || ready_mode) begin
            nxt_alert = 1'b0;
            nxt_exceed_cnt = 3'h0;
        end
    end

    // Configuration and limit registers
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            cfg_ff <= `ATAC_CFG_RESET;
            lower_limit_ff <= `ATAC_LOWER_RESET;
            upper_limit_ff <= `ATAC_UPPER_RESET;
        end else if (CE_IN && WR_EN_IN) begin
            case (WR_PTR_IN)
                `ATAC_PTR_CONFIG: cfg_ff <= WR_DATA_IN;
                `ATAC_PTR_LOWER: lower_limit_ff <= WR_DATA_IN;
                `ATAC_PTR_UPPER: upper_limit_ff <= WR_DATA_IN;
                default: cfg_ff <= cfg_ff;
            endcase
        end
    end

    // Read data, status bit reflects conversion activity
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            rd_data_ff <= 16'h0000;
        end else if (CE_IN) begin
            case (RD_PTR_IN)
                `ATAC_PTR_CONFIG: rd_data_ff <= {conversion_status_bit, cfg_ff[14:0]};
                `ATAC_PTR_LOWER: rd_data_ff <= lower_limit_ff;
                `ATAC_PTR_UPPER: rd_data_ff <= upper_limit_ff;
                default: rd_data_ff <= 16'h0000;
            endcase
        end
    end
    assign RD_DATA_OUT = rd_data_ff;

    // Comparator state
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            exceed_cnt_ff <= 3'h0;
            alert_ff <= 1'b0;
        end else if (CE_IN) begin
            exceed_cnt_ff <= nxt_exceed_cnt;
            alert_ff <= nxt_alert;
        end
    end

    // Alert response: answer only if no lower address already won arbitration
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            ara_valid_ff <= 1'b0;
            ara_addr_ff <= 7'h00;
        end else if (CE_IN) begin
            ara_valid_ff <= ARA_IN && alert_ff && alert_hold_enable && ARA_BUS_ADDR_IN >= OWN_ADDR_IN;
            ara_addr_ff <= OWN_ADDR_IN;
        end
    end
    assign ARA_ADDR_VALID_OUT = ara_valid_ff;
    assign ARA_ADDR_OUT = ara_addr_ff;

    // Ready pulse after each completed conversion in continuous mode
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            pulse_cnt_ff <= 4'h0;
        end else if (CE_IN) begin
            if (CONV_DONE_IN && ready_mode && !cfg_ff[`ATAC_BIT_MODE]) begin
                pulse_cnt_ff <= `ATAC_READY_PULSE_CYC;
            end else if (pulse_cnt_ff != 4'h0) begin
                pulse_cnt_ff <= pulse_cnt_ff - 4'h1;
            end
        end
    end

    // Pin function selection
    always_ff @(posedge CLOCK_IN) begin
        if (!NRST_IN) begin
            state_ff <= atac_pkg::ATAC_IDLE;
        end else if (CE_IN) begin
            if (alert_queue_count == `ATAC_QUE_DISABLE) begin
                state_ff <= atac_pkg::ATAC_IDLE;
            end else if (ready_mode) begin
                state_ff <= atac_pkg::ATAC_READY;
            end else begin
                state_ff <= atac_pkg::ATAC_ALERT;
            end
        end
    end

    always_comb begin
        case (state_ff)
            atac_pkg::ATAC_ALERT: active = alert_ff;
            atac_pkg::ATAC_READY: active = cfg_ff[`ATAC_BIT_MODE] ? conversion_status_bit : (pulse_cnt_ff != 4'h0);
            default: active = 1'b0;
        endcase
    end
    assign ALERT_O_OUT = alert_pin_polarity ? active : ~active;
    assign ALERT_OE_OUT = (state_ff != atac_pkg::ATAC_IDLE);
endmodule : atac_core

//--- verification/atac_props.sv
/* Concurrent checks on the alert control ports.
   Assumes a bind onto atac_core from the bench top file. */
module atac_props (
    input wire logic CLOCK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire logic WR_EN_IN,
    input wire logic [1:0] WR_PTR_IN,
    input wire logic [15:0] WR_DATA_IN,
    input wire logic [1:0] RD_PTR_IN,
    input wire logic [15:0] RD_DATA_OUT,
    input wire logic DATA_READ_IN,
    input wire logic CONV_DONE_IN,
    input wire logic ARA_IN,
    input wire logic [6:0] OWN_ADDR_IN,
    input wire logic [6:0] ARA_BUS_ADDR_IN,
    input wire logic ARA_ADDR_VALID_OUT,
    input wire logic [6:0] ARA_ADDR_OUT,
    input wire logic ALERT_O_OUT,
    input wire logic ALERT_OE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic cfg_wr = CE_IN && WR_EN_IN && WR_PTR_IN == 2'h1;
    default clocking @(posedge CLOCK_IN);
    endclocking
    default disable iff (!NRST_IN);
    chk_reset_quiet: assert property ($rose(NRST_IN) |-> !ALERT_OE_OUT && !ARA_ADDR_VALID_OUT)
        else $error("outputs active after reset");
    // Pin function follows the config register one cycle after the write lands
    chk_queue_float: assert property (cfg_wr && WR_DATA_IN[1:0] == 2'h3 |=> ##1 !ALERT_OE_OUT)
        else $error("pin driven with queue 3");
    chk_queue_drive: assert property (cfg_wr && WR_DATA_IN[1:0] != 2'h3 |=> ##1 ALERT_OE_OUT)
        else $error("pin floats with queue enabled");
    chk_null_read: assert property (CE_IN && RD_PTR_IN == 2'h0 |=> RD_DATA_OUT == 16'h0000)
        else $error("pointer 0 read not zero");
    chk_answer_own: assert property (ARA_ADDR_VALID_OUT |-> $past(ARA_IN) && ARA_ADDR_OUT == OWN_ADDR_IN)
        else $error("response answer wrong");
    chk_answer_low: assert property (ARA_ADDR_VALID_OUT |-> $past(ARA_BUS_ADDR_IN) >= OWN_ADDR_IN)
        else $error("answered against a lower address");
    chk_ce_freeze: assert property (!CE_IN |=> $stable(ALERT_O_OUT) && $stable(RD_DATA_OUT))
        else $error("state moved with enable low");
    chk_pin_steady: assert property ((!CONV_DONE_IN && !WR_EN_IN)[*4] ##0 (!DATA_READ_IN && !ARA_IN)
        |=> $stable(ALERT_O_OUT))
        else $error("pin changed without cause");
endmodule : atac_props

//--- verification/atac_host.sv
/* Host model: register access, data-read and alert-response strobes.
   Assumes the bench calls its tasks and supplies the clock. */
module atac_host (
    input wire logic clk_in,
    input wire logic [15:0] rd_data_in,
    output logic wr_en_out = 1'b0,
    output logic [1:0] wr_ptr_out = 2'h0,
    output logic [15:0] wr_data_out = 16'h0000,
    output logic [1:0] rd_ptr_out = 2'h0,
    output logic data_read_out = 1'b0,
    output logic ara_out = 1'b0,
    output logic [6:0] ara_addr_out = 7'h7f
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic step;
        @(posedge clk_in);
        #1;
    endtask : step
    task automatic wr(input logic [1:0] p, input logic [15:0] d);
        step();
        wr_ptr_out = p;
        wr_data_out = d;
        wr_en_out = 1'b1;
        step();
        wr_en_out = 1'b0;
        wr_data_out = ~d;
    endtask : wr
    task automatic rd(input logic [1:0] p, output logic [15:0] d);
        step();
        rd_ptr_out = p;
        step();
        d = rd_data_in;
    endtask : rd
    task automatic strobe(input logic resp, input logic [6:0] a);
        step();
        ara_addr_out = a;
        ara_out = resp;
        data_read_out = !resp;
        step();
        ara_out = 1'b0;
        data_read_out = 1'b0;
    endtask : strobe
endmodule : atac_host

//--- verification/atac_core_test.sv
/* Self-checking bench for atac_core driven through the host model.
   Assumes package, core, host model and checker are compiled first. */
module atac_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic busy = 1'b0;
    logic done = 1'b0;
    logic [15:0] res = 16'h0000;
    logic we, drd, ara, av, ao, aoe;
    logic [1:0] wp, rp;
    logic [15:0] wd, rdat, rdd;
    logic [6:0] bus, aadr;
    int err_count = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    atac_host host (.clk_in(clk), .rd_data_in(rdat), .wr_en_out(we), .wr_ptr_out(wp), .wr_data_out(wd),
        .rd_ptr_out(rp), .data_read_out(drd), .ara_out(ara), .ara_addr_out(bus));
    atac_core uut (.CLOCK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .WR_EN_IN(we), .WR_PTR_IN(wp), .WR_DATA_IN(wd),
        .RD_PTR_IN(rp), .RD_DATA_OUT(rdat), .DATA_READ_IN(drd), .CONV_DONE_IN(done), .CONV_RESULT_IN(res),
        .CONV_BUSY_IN(busy), .ARA_IN(ara), .OWN_ADDR_IN(7'h48), .ARA_BUS_ADDR_IN(bus),
        .ARA_ADDR_VALID_OUT(av), .ARA_ADDR_OUT(aadr), .ALERT_O_OUT(ao), .ALERT_OE_OUT(aoe));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic pin(input logic e);
        chk({14'h0000, aoe, ao}, {14'h0001, e});
    endtask : pin
    task automatic cp(input logic [15:0] r, input logic e);
        host.step();
        res = r;
        done = 1'b1;
        host.step();
        done = 1'b0;
        res = ~r;
        pin(e);
    endtask : cp
    task automatic setc(input logic [4:0] f);
        host.wr(2'h1, {11'h02c, f});
        host.step();
    endtask : setc
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        #20000;
        err_count++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        host.rd(2'h1, rdd);
        chk(rdd, 16'h8583);
        host.rd(2'h2, rdd);
        chk(rdd, 16'h8000);
        host.rd(2'h3, rdd);
        chk(rdd, 16'h7fff);
        host.rd(2'h0, rdd);
        chk({15'h0000, aoe}, 16'h0000);
        $display("reset test done");
        host.wr(2'h2, 16'h0100);
        host.wr(2'h3, 16'h0200);
        setc(5'h00);
        pin(1'b1);
        cp(16'h0300, 1'b0);
        cp(16'h0150, 1'b0);
        ce = 1'b0;
        cp(16'hff00, 1'b0);
        ce = 1'b1;
        cp(16'hff00, 1'b1);
        setc(5'h10);
        cp(16'hff00, 1'b0);
        cp(16'h0150, 1'b1);
        setc(5'h18);
        pin(1'b0);
        cp(16'h0300, 1'b1);
        $display("comparator test done");
        for (int q = 0; q < 3; q++) begin
            setc({3'h4, q[1:0]});
            cp(16'h0150, 1'b1);
            repeat ((1 << q) - 1) cp(16'h0300, 1'b1);
            cp(16'h0300, 1'b0);
        end
        setc(5'h14);
        cp(16'h0300, 1'b0);
        cp(16'h0150, 1'b0);
        host.strobe(1'b0, 7'h7f);
        pin(1'b1);
        cp(16'h0300, 1'b0);
        host.strobe(1'b1, 7'h10);
        chk({15'h0000, av}, 16'h0000);
        host.strobe(1'b1, 7'h48);
        chk({8'h00, av, aadr}, 16'h00c8);
        pin(1'b1);
        setc(5'h03);
        chk({15'h0000, aoe}, 16'h0000);
        $display("queue and hold tests done");
        host.wr(2'h2, 16'h0000);
        host.wr(2'h3, 16'h8000);
        setc(5'h00);
        pin(1'b0);
        busy = 1'b1;
        host.rd(2'h1, rdd);
        chk(rdd, 16'h0580);
        pin(1'b1);
        busy = 1'b0;
        // Continuous conversion: pin pulses for two cycles per completed conversion
        host.wr(2'h1, 16'h0480);
        host.step();
        pin(1'b1);
        cp(16'h0000, 1'b0);
        host.step();
        pin(1'b0);
        host.step();
        pin(1'b1);
        $display("ready test done");
        final_report();
    end
endmodule : atac_core_test
bind atac_core atac_props chk_i (.*);
